// ==== shared/oag_pkg.sv ====
/*
 Constants and types for the operand address generator.
 Assumes a core sequencer that presents one addressing request at a time.
*/
package oag_pkg;
	localparam int ADDR_W = 16;
	localparam int REG_W = 8;
	localparam int WREG_CNT = 16;
	localparam logic [1:0] SZ_BIT = 2'h0;
	localparam logic [1:0] SZ_NIBBLE = 2'h1;
	localparam logic [1:0] SZ_BYTE = 2'h2;
	localparam logic [1:0] SZ_WORD = 2'h3;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] ADDR_STEP = 16'h0001;
	typedef enum logic [3:0]
	{
		MODE_REG_POSTINC = 4'h0,
		MODE_REG_BIT = 4'h1,
		MODE_MEM_DIRECT = 4'h2,
		MODE_MEM_INDIRECT = 4'h3,
		MODE_MEM_POSTINC = 4'h4,
		MODE_MEM_PREDEC = 4'h5,
		MODE_IDX_SHORT = 4'h6,
		MODE_IDX_LONG = 4'h7,
		MODE_IDX_REG = 4'h8,
		MODE_MEM_BIT = 4'h9
	} mode_type;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_FIRST = 2'h1,
		ST_SECOND = 2'h3,
		ST_UPDATE = 2'h2
	} state_type;
endpackage : oag_pkg

// ==== core/operand_address_generator.sv ====
/*
 Operand address generator: forms register-file and memory effective addresses.
 Assumes the working registers are read combinationally through wregData and that
 the core holds start for one cycle only while busy is low.
*/
// Functional notes
// RULE1 - Post-increment both pointers after the transfer
// RULE2 - Memory pointer pair, register pointer single register
// RULE3 - Only working registers hold indirect addresses
// RULE4 - Any bit of any working register selectable
// RULE5 - Memory access targets last selected space
// RULE6 - Memory addresses are 16 bits wide
// RULE7 - Direct mode uses instruction address, immediate source
// RULE8 - Indirect mode address from working register pair
// RULE9 - Word operations access two consecutive locations
// RULE10 - Post-increment pair after the access
// RULE11 - Pre-decrement pair, write back, then access (code issues the writeback in the same cycle as the access)
// RULE12 - Indexed: pair plus byte or word offset
// RULE13 - Register offset: sum of two even pairs
// RULE14 - Bit test-and-set addresses any memory bit
// RULE15 - Operand sizes bit, nibble, byte, word
// RULE16 - All address arithmetic wraps modulo 65536
// RULE17 - Word high byte at lower address
`timescale 1ns/100ps
module operand_address_generator #(
	parameter int WREGS = 16
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic start,
	input wire logic [3:0] mode,
	input wire logic [1:0] opSize,
	input wire logic [3:0] ptrSel,
	input wire logic [3:0] auxSel,
	input wire logic [2:0] bitSel,
	input wire logic [15:0] immAddr,
	input wire logic longOffset,
	input wire logic immSource,
	input wire logic selProgram,
	input wire logic selData,
	input wire logic [WREGS*8-1:0] wregData,
	output logic busy,
	output logic memValid,
	output logic [15:0] memAddr,
	output logic memProgram,
	output logic byteHigh,
	output logic regValid,
	output logic [7:0] regAddr,
	output logic [2:0] bitIndex,
	output logic bitOp,
	output logic [1:0] sizeOut,
	output logic useImmediate,
	output logic wbValid,
	output logic [3:0] wbSel,
	output logic [15:0] wbValue,
	output logic wbPair,
	output logic done
);
	function automatic logic [7:0] wreg(input logic [WREGS*8-1:0] f, input logic [3:0] n);
		wreg = f[n*8 +: 8];
	endfunction : wreg
	// Pair is always even-aligned so odd selectors cannot split a pointer
	function automatic logic [15:0] wpair(input logic [WREGS*8-1:0] f, input logic [3:0] n);
		wpair = {wreg(f, {n[3:1], 1'b0}), wreg(f, {n[3:1], 1'b1})};
	endfunction : wpair
	function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
		add16 = a + b;
	endfunction : add16

	oag_pkg::state_type state;
	oag_pkg::state_type next_state;
	logic spaceProgram;
	oag_pkg::mode_type curMode;
	logic [1:0] curSize;
	logic [15:0] baseAddr;
	logic [3:0] curPtr;
	logic [3:0] curAux;
	logic [7:0] regPtr;

	wire logic [15:0] ptrPair = wpair(wregData, ptrSel); // [RULE8] [RULE3]
	wire logic [15:0] auxPair = wpair(wregData, auxSel);
	wire logic [15:0] shortOff = {8'h00, immAddr[7:0]};
	wire logic [15:0] offset = longOffset ? immAddr : shortOff; // [RULE12]
	wire oag_pkg::mode_type reqMode = oag_pkg::mode_type'(mode);
	wire logic isWord = (opSize == oag_pkg::SZ_WORD); // [RULE15]
	wire logic isRegMode = (reqMode == oag_pkg::MODE_REG_POSTINC) ||
		(reqMode == oag_pkg::MODE_REG_BIT);
	logic [15:0] effAddr;
	always_comb
	begin
		case (reqMode)
			oag_pkg::MODE_MEM_DIRECT: effAddr = immAddr; // [RULE7]
			oag_pkg::MODE_MEM_PREDEC: effAddr = add16(ptrPair, 16'hffff); // [RULE11] [RULE16]
			oag_pkg::MODE_IDX_SHORT: effAddr = add16(ptrPair, offset);
			oag_pkg::MODE_IDX_LONG: effAddr = add16(ptrPair, offset); // [RULE12]
			oag_pkg::MODE_IDX_REG: effAddr = add16(ptrPair, auxPair); // [RULE13] [RULE16]
			default: effAddr = ptrPair; // [RULE2] [RULE10] [RULE14]
		endcase
	end
	wire logic secondByte = (curSize == oag_pkg::SZ_WORD) && (state == oag_pkg::ST_FIRST);
	wire logic needUpdate = (curMode == oag_pkg::MODE_REG_POSTINC) ||
		(curMode == oag_pkg::MODE_MEM_POSTINC);
	wire logic [15:0] incPair = add16(baseAddr, oag_pkg::ADDR_STEP); // [RULE16]
	wire logic [15:0] secondAddr = add16(memAddr, oag_pkg::ADDR_STEP); // [RULE9]

	always_comb
	begin
		next_state = state;
		case (state)
			oag_pkg::ST_IDLE: if (start) next_state = oag_pkg::ST_FIRST;
			oag_pkg::ST_FIRST:
				if (secondByte) next_state = oag_pkg::ST_SECOND;
				else if (needUpdate) next_state = oag_pkg::ST_UPDATE;
				else next_state = oag_pkg::ST_IDLE;
			oag_pkg::ST_SECOND:
				next_state = needUpdate ? oag_pkg::ST_UPDATE : oag_pkg::ST_IDLE;
			oag_pkg::ST_UPDATE: next_state = oag_pkg::ST_IDLE;
			default: next_state = oag_pkg::ST_IDLE;
		endcase
	end

	// Space select persists across instructions; last one executed wins
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst) spaceProgram <= 1'b0;
		else if (selProgram) spaceProgram <= 1'b1; // [RULE5]
		else if (selData) spaceProgram <= 1'b0;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state <= oag_pkg::ST_IDLE;
			curMode <= oag_pkg::MODE_MEM_DIRECT;
			curSize <= oag_pkg::SZ_BYTE;
			baseAddr <= oag_pkg::ADDR_RESET;
			curPtr <= 4'h0;
			curAux <= 4'h0;
			regPtr <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (state == oag_pkg::ST_IDLE && start)
			begin
				curMode <= reqMode;
				curSize <= opSize;
				baseAddr <= ptrPair;
				curPtr <= {ptrSel[3:1], 1'b0};
				curAux <= auxSel;
				regPtr <= wreg(wregData, auxSel); // [RULE2]
			end
		end
	end

	// Outputs registered; address phase issued in ST_FIRST/ST_SECOND
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			busy <= 1'b0;
			memValid <= 1'b0;
			memAddr <= oag_pkg::ADDR_RESET;
			memProgram <= 1'b0;
			byteHigh <= 1'b0;
			regValid <= 1'b0;
			regAddr <= 8'h00;
			bitIndex <= 3'h0;
			bitOp <= 1'b0;
			sizeOut <= oag_pkg::SZ_BYTE;
			useImmediate <= 1'b0;
			wbValid <= 1'b0;
			wbSel <= 4'h0;
			wbValue <= oag_pkg::ADDR_RESET;
			wbPair <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			busy <= (next_state != oag_pkg::ST_IDLE);
			memValid <= 1'b0;
			regValid <= 1'b0;
			wbValid <= 1'b0;
			done <= 1'b0;
			if (state == oag_pkg::ST_IDLE && start)
			begin
				memValid <= !(reqMode == oag_pkg::MODE_REG_BIT);
				memAddr <= effAddr; // [RULE6]
				memProgram <= selProgram ? 1'b1 : (selData ? 1'b0 : spaceProgram);
				byteHigh <= isWord; // [RULE17]
				regValid <= isRegMode; // [RULE3]
				regAddr <= (reqMode == oag_pkg::MODE_REG_BIT) ? {4'h0, ptrSel} :
					wreg(wregData, auxSel);
				bitIndex <= bitSel; // [RULE4] [RULE14]
				bitOp <= (reqMode == oag_pkg::MODE_REG_BIT) ||
					(reqMode == oag_pkg::MODE_MEM_BIT);
				sizeOut <= opSize; // [RULE15]
				useImmediate <= immSource && (reqMode == oag_pkg::MODE_MEM_DIRECT ||
					reqMode == oag_pkg::MODE_MEM_INDIRECT); // [RULE7]
				// Pre-decrement writes back alongside the access address
				wbValid <= (reqMode == oag_pkg::MODE_MEM_PREDEC); // [RULE11]
				wbSel <= {ptrSel[3:1], 1'b0};
				wbValue <= effAddr;
				wbPair <= 1'b1;
			end
			else if (next_state == oag_pkg::ST_SECOND)
			begin
				memValid <= 1'b1;
				memAddr <= secondAddr; // [RULE9] [RULE16]
				byteHigh <= 1'b0; // [RULE17]
			end
			else if (next_state == oag_pkg::ST_UPDATE)
			begin
				wbValid <= 1'b1; // [RULE1] [RULE10]
				wbSel <= curPtr;
				wbValue <= incPair;
				wbPair <= 1'b1;
			end
			else if (state == oag_pkg::ST_UPDATE && curMode == oag_pkg::MODE_REG_POSTINC)
			begin
				wbValid <= 1'b1; // [RULE1]
				wbSel <= curAux;
				wbValue <= {8'h00, regPtr + 8'h01};
				wbPair <= 1'b0;
			end
			if (state != oag_pkg::ST_IDLE && next_state == oag_pkg::ST_IDLE)
				done <= 1'b1;
		end
	end

	a_second_addr: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
		(state == oag_pkg::ST_SECOND) |-> memAddr == $past(memAddr) + 16'h0001)
		else $error("Second byte address not consecutive");
	a_space_hold: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
		$rose(memValid) && !$past(selProgram) && !$past(selData)
		|-> memProgram == $past(spaceProgram))
		else $error("Memory space not last selected");
	a_postinc_after: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
		(state == oag_pkg::ST_UPDATE) |-> $past(memValid, 1) || $past(memValid, 2))
		else $error("Increment before access");
	// Ties the written-back pointer to the pair as it stood when the request was taken
	a_predec_value: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
		wbValid && state == oag_pkg::ST_FIRST && curMode == oag_pkg::MODE_MEM_PREDEC
		|-> wbValue == memAddr && wbValue == $past(ptrPair) - 16'h0001)
		else $error("Predecrement writeback differs from access");
	a_pair_even: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
		wbValid && wbPair |-> !wbSel[0])
		else $error("Pointer pair not even");
	a_reg_inc: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
		wbValid && !wbPair |-> wbValue[7:0] == regPtr + 8'h01 && wbSel == curAux &&
		curMode == oag_pkg::MODE_REG_POSTINC)
		else $error("Register pointer increment wrong");
	a_word_high: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
		(state == oag_pkg::ST_SECOND) |-> !byteHigh && $past(byteHigh))
		else $error("Word byte order wrong");
	a_busy_done: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
		done |-> !busy ##1 !done)
		else $error("Done while busy");
	c_word: cover property (@(posedge mclk) disable iff (rst) state == oag_pkg::ST_SECOND);
	c_postinc: cover property (@(posedge mclk) disable iff (rst)
		state == oag_pkg::ST_UPDATE && curMode == oag_pkg::MODE_REG_POSTINC);
	c_predec: cover property (@(posedge mclk) disable iff (rst)
		wbValid && curMode == oag_pkg::MODE_MEM_PREDEC);
endmodule : operand_address_generator

// ==== dv/wreg_model.sv ====
/*
 Working register file model that sits across from the operand address generator.
 Assumes the bench preloads registers and the generator writes pointers back.
*/
`timescale 1ns/100ps
module wreg_model
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic loadEn,
	input wire logic [3:0] loadSel,
	input wire logic [7:0] loadVal,
	input wire logic wbValid,
	input wire logic [3:0] wbSel,
	input wire logic [15:0] wbValue,
	input wire logic wbPair,
	output logic [127:0] wregData
);
	// Bench loads win over writebacks; they never overlap in the bench sequence
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			wregData <= '0;
		else if (loadEn)
			wregData[loadSel*8 +: 8] <= loadVal;
		else if (wbValid && wbPair)
			wregData[wbSel[3:1]*16 +: 16] <= {wbValue[7:0], wbValue[15:8]};
		else if (wbValid)
			wregData[wbSel*8 +: 8] <= wbValue[7:0];
	end
endmodule : wreg_model

// ==== dv/test_operand_address_generator.sv ====
/*
 Self-checking bench for the operand address generator.
 Assumes wreg_model returns pointer writebacks to the working registers.
*/
`timescale 1ns/100ps
module test_operand_address_generator;
	typedef struct packed {logic [1:0] kind; logic [3:0] sel; logic flag; logic [15:0] val;
		logic bop; logic [1:0] size; logic [2:0] bix;} note_type;
	logic mclk = 0, rst = 1, start = 0, lng = 0, ims = 0, selP = 0, selD = 0, ldEn = 0, sp = 0;
	logic [3:0] md = 0, p = 0, a = 0, ldSel = 0, wbSel;
	logic [1:0] sz = 0, sizeOut;
	logic bitOp;
	logic [2:0] bt = 0, bitIndex;
	logic [15:0] imm = 0, rnd = 16'h003a, memAddr, wbValue;
	logic [7:0] ldVal = 0, regAddr, r [16];
	logic [127:0] wregData;
	logic busy, memValid, memProgram, byteHigh, regValid, useImmediate, wbValid, wbPair, done;
	note_type q [$];
	int n_mismatch = 0, comparisons = 0;
	always #25 mclk = ~mclk;
	operand_address_generator #(.WREGS(16)) operand_address_generator_i (.mclk(mclk), .rst(rst),
		.start(start), .mode(md), .opSize(sz), .ptrSel(p), .auxSel(a), .bitSel(bt),
		.immAddr(imm), .longOffset(lng), .immSource(ims), .selProgram(selP), .selData(selD),
		.wregData(wregData), .busy(busy), .memValid(memValid), .memAddr(memAddr),
		.memProgram(memProgram), .byteHigh(byteHigh), .regValid(regValid), .regAddr(regAddr),
		.bitIndex(bitIndex), .bitOp(bitOp), .sizeOut(sizeOut), .useImmediate(useImmediate),
		.wbValid(wbValid), .wbSel(wbSel), .wbValue(wbValue), .wbPair(wbPair), .done(done));
	wreg_model wreg_model_i (.mclk(mclk), .rst(rst), .loadEn(ldEn), .loadSel(ldSel),
		.loadVal(ldVal), .wbValid(wbValid), .wbSel(wbSel), .wbValue(wbValue), .wbPair(wbPair),
		.wregData(wregData));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function automatic logic [15:0] pr(input logic [3:0] x);
		return {r[{x[3:1], 1'b0}], r[{x[3:1], 1'b1}]};
	endfunction : pr
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
	begin
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	end
	endtask : cmp
	task automatic wrap_up();
	begin
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask : wrap_up
	task automatic note(input logic [1:0] k, input logic [3:0] s, input logic f,
		input logic [15:0] v, input logic [5:0] ob);
		q.push_back({k, s, f, v, ob});
	endtask : note
	// Local copy tracks the model so later pointers are predicted, not read back
	task automatic wb(input logic [3:0] s, input logic pair, input logic [15:0] v);
	begin
		note(2'h2, s, pair, v, 6'h00);
		if (pair)
			{r[{s[3:1], 1'b0}], r[{s[3:1], 1'b1}]} = v;
		else
			r[s] = v[7:0];
	end
	endtask : wb
	task automatic take(input logic [1:0] k, output note_type n);
	begin
		n = q.size() > 0 ? q.pop_front() : '0;
		cmp("noteKind", {14'h0, k}, {14'h0, n.kind});
	end
	endtask : take
	always @(negedge mclk)
	begin
		note_type n;
		if (memValid === 1'b1)
		begin
			take(2'h0, n);
			cmp("memAddr", n.val, memAddr);
			cmp("memProgram", {15'h0, n.flag}, {15'h0, memProgram});
			cmp("memSizeOut", {14'h0, n.size}, {14'h0, sizeOut});
			cmp("memBitOp", {15'h0, n.bop}, {15'h0, bitOp});
			if (n.bop)
				cmp("memBitIndex", {13'h0, n.bix}, {13'h0, bitIndex});
			if (n.sel[1])
				cmp("byteHigh", {15'h0, n.sel[0]}, {15'h0, byteHigh});
			if (n.sel[3])
				cmp("useImmediate", {15'h0, n.sel[2]}, {15'h0, useImmediate});
		end
		if (regValid === 1'b1)
		begin
			take(2'h1, n);
			cmp("regAddr", {8'h00, n.val[7:0]}, {8'h00, regAddr});
			cmp("regSizeOut", {14'h0, n.size}, {14'h0, sizeOut});
			cmp("regBitOp", {15'h0, n.bop}, {15'h0, bitOp});
			if (n.sel[0])
				cmp("bitIndex", {13'h0, n.val[10:8]}, {13'h0, bitIndex});
		end
		if (wbValid === 1'b1)
		begin
			take(2'h2, n);
			cmp("wbSel", {12'h0, n.sel}, {12'h0, wbSel});
			cmp("wbPair", {15'h0, n.flag}, {15'h0, wbPair});
			cmp("wbValue", n.val & (n.flag ? 16'hffff : 16'h00ff),
				wbValue & (n.flag ? 16'hffff : 16'h00ff));
		end
	end
	task automatic go(input logic [3:0] m, input logic [1:0] s, input logic [3:0] pp,
		input logic [15:0] ii);
		logic [15:0] pv;
		logic [15:0] ea;
		logic [5:0] ob;
		int k;
	begin
		@(posedge mclk);
		#2;
		{md, sz, p, a, bt, lng, ims} = {m, s, pp, ~pp[3], rnd[6:4], rnd[9:7], m == 4'h7, rnd[10]};
		imm = ii;
		ob = {m == 4'h1 || m == 4'h9, s, bt};
		pv = pr(pp);
		case (m)
			4'h2: ea = imm;
			4'h5: ea = pv - 16'h0001;
			4'h6: ea = pv + {8'h00, imm[7:0]};
			4'h7: ea = pv + imm;
			4'h8: ea = pv + pr(a);
			default: ea = pv;
		endcase
		if (m == 4'h1)
			note(2'h1, 4'h1, 1'b0, {5'h00, bt, 4'h0, pp}, ob);
		else
		begin
			// Byte order and immediate flag are checked on every first access, not just some
			note(2'h0, {1'b1, ims && (m == 4'h2 || m == 4'h3), 1'b1, s == 2'h3}, sp, ea, ob);
			if (m == 4'h5)
				wb(pp & 4'he, 1'b1, ea);
			if (m == 4'h0)
				note(2'h1, 4'h0, 1'b0, {8'h00, r[a]}, ob);
			if (s == 2'h3)
				note(2'h0, 4'h2, sp, ea + 16'h0001, ob);
			if (m == 4'h0 || m == 4'h4)
				wb(pp & 4'he, 1'b1, pv + 16'h0001);
			if (m == 4'h0)
				wb(a, 1'b0, {8'h00, r[a] + 8'h01});
		end
		start = 1'b1;
		@(posedge mclk);
		#2;
		start = 1'b0;
		cmp("busyTaken", 16'h0001, {15'h0, busy});
		for (k = 0; k < 30 && done !== 1'b1; k++)
			@(negedge mclk);
		cmp("doneSeen", 16'h0001, {15'h0, done});
		cmp("busyDone", 16'h0000, {15'h0, busy});
	end
	endtask : go
	task automatic load(input logic [3:0] s, input logic [7:0] v);
	begin
		@(posedge mclk);
		#2;
		{ldEn, ldSel, ldVal} = {1'b1, s, v};
		r[s] = v;
		@(posedge mclk);
		#2;
		ldEn = 1'b0;
	end
	endtask : load
	task automatic space(input logic prg);
	begin
		@(posedge mclk);
		#2;
		{selP, selD, sp} = {prg, ~prg, prg};
		@(posedge mclk);
		#2;
		{selP, selD} = 2'b00;
	end
	endtask : space
	initial
	begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		#2;
		rst = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			rnd = lfsr(rnd);
			load(i[3:0], rnd[7:0]);
		end
		// Data space first without a select, so the reset default is exercised
		for (int s = 0; s < 2; s++)
		begin
			if (s == 1)
				space(1'b1);
			// Bit and nibble sizes too, so every operand size reaches sizeOut
			for (int m = 0; m < 10; m++)
				for (int z = 0; z < 4; z++)
				begin
					rnd = lfsr(rnd);
					if (z < 3 || m inside {2, 3, 5, 6, 7, 8})
						go(m[3:0], z[1:0], rnd[3:0], rnd);
				end
		end
		space(1'b0);
		go(4'h2, 2'h3, 4'h0, 16'hffff);
		load(4'h0, 8'hff);
		load(4'h1, 8'hff);
		go(4'h4, 2'h2, 4'h1, 16'h0000);
		go(4'h5, 2'h2, 4'h0, 16'h0000);
		cmp("queueLeft", 16'h0000, 16'(q.size()));
		wrap_up();
	end
endmodule : test_operand_address_generator
